// >>> inc/ufc_pkg.sv
package ufc_pkg;

   // Register offsets, index is the serial port
   localparam logic [1:0][7:0] OFF_SERIAL_CONTROL = {8'hc0, 8'h98};
   localparam logic [1:0][7:0] OFF_OWN_ADDRESS    = {8'haa, 8'ha9};
   localparam logic [1:0][7:0] OFF_ADDRESS_MASK   = {8'hba, 8'hb9};
   localparam logic [1:0][7:0] OFF_BAUD_CONTROL   = {8'h82, 8'h81};
   localparam logic [7:0]      OFF_POWER_CONTROL  = 8'h80;
   localparam logic [7:0]      OFF_TIMER_TWO_CTRL = 8'h83;
   localparam logic [7:0]      OFF_IRQ_STATUS     = 8'h84;
   localparam logic [7:0]      OFF_IRQ_MASK       = 8'h85;

   // Serial control register bit positions
   localparam int SC_TOP  = 7;
   localparam int SC_MOD1 = 6;
   localparam int SC_MPE  = 5;
   localparam int SC_REN  = 4;
   localparam int SC_TB8  = 3;
   localparam int SC_RB8  = 2;
   localparam int SC_TI   = 1;
   localparam int SC_RI   = 0;

   // Power, baud and timer-two control bit positions
   localparam int PC_FCE0 = 6;
   localparam int BC_FCE1 = 6;
   localparam int BC_TXBG = 3;
   localparam int BC_RXBG = 2;
   localparam int T2_RXT2 = 5;
   localparam int T2_TXT2 = 4;

   // Interrupt status layout: three events per port
   localparam int IRQ_RI     = 0;
   localparam int IRQ_TI     = 1;
   localparam int IRQ_FE     = 2;
   localparam int IRQ_STRIDE = 3;
   localparam int IRQ_W      = 6;

   // Reset values
   localparam logic [7:0]       REG_RESET = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;

   // Serial port modes, {mode bit 0, mode bit 1}
   typedef enum logic [1:0] {
      UFC_MODE_SHIFT = 2'b00,
      UFC_MODE_UART8 = 2'b01,
      UFC_MODE_UART9F = 2'b10,
      UFC_MODE_UART9V = 2'b11
   } ufc_mode_e;

   // Receiver core strobes for one frame
   typedef struct packed {
      logic       last_data;
      logic       stop;
      logic [7:0] data;
      logic       ninth;
      logic       stop_bit;
   } ufc_rx_evt_s;

   // Decisions taken for one frame
   typedef struct packed {
      logic ri_set;
      logic fe_set;
      logic rb8_load;
      logic rb8;
   } ufc_rx_act_s;

   // Control handed to the shifting core
   typedef struct packed {
      ufc_mode_e mode;
      logic      rx_enable;
      logic      tb8;
      logic      ri;
      logic      ti;
   } ufc_ctrl_s;

endpackage

// >>> hdl/ufc_rx_filter.sv
module ufc_rx_filter (
   // Port configuration
   input  ufc_pkg::ufc_mode_e   mode_i,
   input  logic                 mpe_i,
   input  logic                 fce_i,
   input  logic [7:0]           own_address_i,
   input  logic [7:0]           own_address_mask_i,
   // Receiver strobes
   input  ufc_pkg::ufc_rx_evt_s evt_i,
   // Frame decisions
   output ufc_pkg::ufc_rx_act_s act_o
);

   logic       async_mode;
   logic       check_on;
   logic       mp_on;
   logic       use_stop;
   logic       moment;
   logic       is_addr;
   logic       given_hit;
   logic       bcast_hit;
   logic       accept;
   logic [7:0] bcast;

   // Shift mode has neither framing check nor filtering
   assign async_mode = mode_i != ufc_pkg::UFC_MODE_SHIFT;
   assign check_on   = fce_i && async_mode;
   assign mp_on      = mpe_i && async_mode;

   // Mode 1 always waits for the stop bit, it may be the ninth bit
   assign use_stop = check_on || mode_i == ufc_pkg::UFC_MODE_UART8;
   assign moment   = use_stop ? evt_i.stop : evt_i.last_data;

   // Given address: zero mask bits are don't-care
   assign given_hit = ((evt_i.data ^ own_address_i) & own_address_mask_i) == 8'h00;
   // Broadcast: ones of address OR mask must arrive
   assign bcast     = own_address_i | own_address_mask_i;
   assign bcast_hit = (~evt_i.data & bcast) == 8'h00;

   // Which frames count as address frames
   always_comb begin
      unique case (mode_i)
         ufc_pkg::UFC_MODE_SHIFT:  is_addr = 1'b0;
         ufc_pkg::UFC_MODE_UART8:  is_addr = evt_i.stop_bit;
         ufc_pkg::UFC_MODE_UART9F,
         ufc_pkg::UFC_MODE_UART9V: is_addr = evt_i.ninth;
      endcase
   end

   // Unfiltered frames always pass
   assign accept = !mp_on || (is_addr && (given_hit || bcast_hit));

   // Decisions, all single-cycle pulses except rb8
   assign act_o.ri_set   = moment && accept;
   assign act_o.fe_set   = check_on && evt_i.stop && !evt_i.stop_bit;
   assign act_o.rb8_load = moment && accept && async_mode;
   assign act_o.rb8      = (mode_i == ufc_pkg::UFC_MODE_UART8) ? evt_i.stop_bit : evt_i.ninth;

endmodule // ufc_rx_filter

// >>> hdl/ufc_uart_frame_check.sv
// Functional notes
// - Framing check only in modes 1-3, per-port enable.
// - Checking on: invalid stop bit sets frame error.
// - Frame error sticky until software clear or reset.
// - Checking on: receive-done at the stop bit.
// - Multiprocessor enable turns on address recognition.
// - Recognition on: receive-done only on given or broadcast match.
// - Mode 1: stop bit is ninth bit; needs match and valid stop.
// - Mode 0 ignores multiprocessor enable.
// - Given address: own address under mask, zero bits don't-care.
// - Broadcast: own address OR mask, zero bits don't-care.
// - Address and mask reset to 00h, accepting all.
// - Port 0 tx clock: generator, else timer 2, else timer 1.
// - Rx clock chosen alike by its own selects.
// - Port 1: own generator selects, shared timer-2 selects.
// - Control bit 7: frame error with checking on, else mode bit 0.
module ufc_uart_frame_check (
   // Clock and reset
   input  logic                           clk_sys_i,
   input  logic                           nrst_i,
   // Register port
   input  logic [7:0]                     addr_i,
   input  logic [7:0]                     wdata_i,
   input  logic                           wr_i,
   input  logic                           rd_i,
   output logic [7:0]                     rdata_o,
   // Receiver and transmitter strobes, one per port
   input  ufc_pkg::ufc_rx_evt_s [1:0]     rx_evt_i,
   input  logic [1:0]                     tx_done_i,
   // Baud tick sources
   input  logic                           timer1_tick_i,
   input  logic                           timer2_tick_i,
   input  logic [1:0]                     baud_gen_tick_i,
   // Port control and selected baud ticks
   output ufc_pkg::ufc_ctrl_s [1:0]       ctrl_o,
   output logic [1:0]                     tx_baud_tick_o,
   output logic [1:0]                     rx_baud_tick_o,
   // Interrupt
   output logic                           irq_o
);

   // Serial control state per port
   logic [1:0]                 serial_mode_bit0;
   logic [1:0]                 serial_mode_bit1;
   logic [1:0]                 multiprocessor_enable;
   logic [1:0]                 rx_enable;
   logic [1:0]                 tx_bit8;
   logic [1:0]                 rx_bit8;
   logic [1:0]                 transmit_done_flag;
   logic [1:0]                 receive_done_flag;
   logic [1:0]                 frame_error_flag;
   // Configuration
   logic [1:0]                 frame_check_enable;
   logic [1:0]                 tx_baudgen_select;
   logic [1:0]                 rx_baudgen_select;
   logic                       tx_timer_two_select;
   logic                       rx_timer_two_select;
   logic [1:0][7:0]            own_address;
   logic [1:0][7:0]            own_address_mask;
   // Interrupt state
   logic [ufc_pkg::IRQ_W-1:0]  irq_status;
   logic [ufc_pkg::IRQ_W-1:0]  irq_mask;
   logic [ufc_pkg::IRQ_W-1:0]  irq_event;
   logic [ufc_pkg::IRQ_W-1:0]  next_irq_status;
   // Decode and frame decisions
   logic [1:0]                 sc_wr;
   logic [1:0]                 oa_wr;
   logic [1:0]                 am_wr;
   logic [1:0]                 bc_wr;
   ufc_pkg::ufc_mode_e [1:0]   mode;
   ufc_pkg::ufc_rx_act_s [1:0] act;
   logic [7:0]                 next_rdata;
   logic                       next_tx_tick [2];
   logic                       next_rx_tick [2];

   // Address compare, shared by write and read decode
   function automatic logic is_at(input logic [7:0] addr, input logic [7:0] off);
      return addr == off;
   endfunction

   // Write strobes per port register
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         sc_wr[i] = wr_i && is_at(addr_i, ufc_pkg::OFF_SERIAL_CONTROL[i]);
         oa_wr[i] = wr_i && is_at(addr_i, ufc_pkg::OFF_OWN_ADDRESS[i]);
         am_wr[i] = wr_i && is_at(addr_i, ufc_pkg::OFF_ADDRESS_MASK[i]);
         bc_wr[i] = wr_i && is_at(addr_i, ufc_pkg::OFF_BAUD_CONTROL[i]);
         mode[i]  = ufc_pkg::ufc_mode_e'({serial_mode_bit0[i], serial_mode_bit1[i]});
      end
   end

   // One frame filter per port
   for (genvar g = 0; g < 2; g++) begin : g_port
      ufc_rx_filter u_filter (
         .mode_i             (mode[g]),
         .mpe_i              (multiprocessor_enable[g]),
         .fce_i              (frame_check_enable[g]),
         .own_address_i      (own_address[g]),
         .own_address_mask_i (own_address_mask[g]),
         .evt_i              (rx_evt_i[g]),
         .act_o              (act[g])
      );
   end

   // Plain serial control bits; bit 7 writes mode only with checking off
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         serial_mode_bit0      <= 2'h0;
         serial_mode_bit1      <= 2'h0;
         multiprocessor_enable <= 2'h0;
         rx_enable             <= 2'h0;
         tx_bit8               <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (sc_wr[i]) begin
               if (!frame_check_enable[i]) begin
                  serial_mode_bit0[i] <= wdata_i[ufc_pkg::SC_TOP];
               end
               serial_mode_bit1[i]      <= wdata_i[ufc_pkg::SC_MOD1];
               multiprocessor_enable[i] <= wdata_i[ufc_pkg::SC_MPE];
               rx_enable[i]             <= wdata_i[ufc_pkg::SC_REN];
               tx_bit8[i]               <= wdata_i[ufc_pkg::SC_TB8];
            end
         end
      end
   end

   // Receive-done flag; set beats clear
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         receive_done_flag <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (act[i].ri_set) begin
               receive_done_flag[i] <= 1'b1;
            end else if (sc_wr[i]) begin
               receive_done_flag[i] <= wdata_i[ufc_pkg::SC_RI];
            end
         end
      end
   end

   // Transmit-done flag, set by the shifting core
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         transmit_done_flag <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (tx_done_i[i]) begin
               transmit_done_flag[i] <= 1'b1;
            end else if (sc_wr[i]) begin
               transmit_done_flag[i] <= wdata_i[ufc_pkg::SC_TI];
            end
         end
      end
   end

   // Frame error: sticky, only software or reset clears it
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         frame_error_flag <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (act[i].fe_set) begin
               frame_error_flag[i] <= 1'b1;
            end else if (sc_wr[i] && frame_check_enable[i]) begin
               frame_error_flag[i] <= wdata_i[ufc_pkg::SC_TOP];
            end
         end
      end
   end

   // Received ninth bit, loaded only for accepted frames
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         rx_bit8 <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (act[i].rb8_load) begin
               rx_bit8[i] <= act[i].rb8;
            end else if (sc_wr[i]) begin
               rx_bit8[i] <= wdata_i[ufc_pkg::SC_RB8];
            end
         end
      end
   end

   // Own address and mask; reset value accepts every address
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         own_address      <= {2{ufc_pkg::REG_RESET}};
         own_address_mask <= {2{ufc_pkg::REG_RESET}};
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (oa_wr[i]) begin
               own_address[i] <= wdata_i;
            end
            if (am_wr[i]) begin
               own_address_mask[i] <= wdata_i;
            end
         end
      end
   end

   // Check enables: port 0 in power control, port 1 in its baud control
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         frame_check_enable <= 2'h0;
      end else begin
         if (wr_i && is_at(addr_i, ufc_pkg::OFF_POWER_CONTROL)) begin
            frame_check_enable[0] <= wdata_i[ufc_pkg::PC_FCE0];
         end
         if (bc_wr[1]) begin
            frame_check_enable[1] <= wdata_i[ufc_pkg::BC_FCE1];
         end
      end
   end

   // Baud source selects
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         tx_baudgen_select   <= 2'h0;
         rx_baudgen_select   <= 2'h0;
         tx_timer_two_select <= 1'b0;
         rx_timer_two_select <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (bc_wr[i]) begin
               tx_baudgen_select[i] <= wdata_i[ufc_pkg::BC_TXBG];
               rx_baudgen_select[i] <= wdata_i[ufc_pkg::BC_RXBG];
            end
         end
         if (wr_i && is_at(addr_i, ufc_pkg::OFF_TIMER_TWO_CTRL)) begin
            tx_timer_two_select <= wdata_i[ufc_pkg::T2_TXT2];
            rx_timer_two_select <= wdata_i[ufc_pkg::T2_RXT2];
         end
      end
   end

   // Tick muxes; generator beats timer 2, timer 2 beats timer 1
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         next_tx_tick[i] = tx_baudgen_select[i] ? baud_gen_tick_i[i] :
                           tx_timer_two_select ? timer2_tick_i : timer1_tick_i;
         next_rx_tick[i] = rx_baudgen_select[i] ? baud_gen_tick_i[i] :
                           rx_timer_two_select ? timer2_tick_i : timer1_tick_i;
      end
   end

   // Modes 0 and 2 have fixed rates; ticks stay low
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         tx_baud_tick_o <= 2'h0;
         rx_baud_tick_o <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            tx_baud_tick_o[i] <= serial_mode_bit1[i] && next_tx_tick[i];
            rx_baud_tick_o[i] <= serial_mode_bit1[i] && next_rx_tick[i];
         end
      end
   end

   // Control to the shifting core
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         ctrl_o <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            ctrl_o[i].mode      <= mode[i];
            ctrl_o[i].rx_enable <= rx_enable[i];
            ctrl_o[i].tb8       <= tx_bit8[i];
            ctrl_o[i].ri        <= receive_done_flag[i];
            ctrl_o[i].ti        <= transmit_done_flag[i];
         end
      end
   end

   // Interrupt events; an event beats its clear
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         irq_event[ufc_pkg::IRQ_STRIDE*i + ufc_pkg::IRQ_RI] = act[i].ri_set;
         irq_event[ufc_pkg::IRQ_STRIDE*i + ufc_pkg::IRQ_TI] = tx_done_i[i];
         irq_event[ufc_pkg::IRQ_STRIDE*i + ufc_pkg::IRQ_FE] = act[i].fe_set;
      end
      next_irq_status = irq_status;
      if (wr_i && is_at(addr_i, ufc_pkg::OFF_IRQ_STATUS)) begin
         next_irq_status = irq_status & ~wdata_i[ufc_pkg::IRQ_W-1:0];
      end
      next_irq_status = next_irq_status | irq_event;
   end

   // Status and mask registers
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         irq_status <= ufc_pkg::IRQ_RESET;
         irq_mask   <= ufc_pkg::IRQ_RESET;
      end else begin
         irq_status <= next_irq_status;
         if (wr_i && is_at(addr_i, ufc_pkg::OFF_IRQ_MASK)) begin
            irq_mask <= wdata_i[ufc_pkg::IRQ_W-1:0];
         end
      end
   end

   // Level interrupt, one cycle behind the status bits
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      next_rdata = 8'h00;
      for (int i = 0; i < 2; i++) begin
         if (is_at(addr_i, ufc_pkg::OFF_SERIAL_CONTROL[i])) begin
            next_rdata[ufc_pkg::SC_TOP]  = frame_check_enable[i] ? frame_error_flag[i]
                                                                 : serial_mode_bit0[i];
            next_rdata[ufc_pkg::SC_MOD1] = serial_mode_bit1[i];
            next_rdata[ufc_pkg::SC_MPE]  = multiprocessor_enable[i];
            next_rdata[ufc_pkg::SC_REN]  = rx_enable[i];
            next_rdata[ufc_pkg::SC_TB8]  = tx_bit8[i];
            next_rdata[ufc_pkg::SC_RB8]  = rx_bit8[i];
            next_rdata[ufc_pkg::SC_TI]   = transmit_done_flag[i];
            next_rdata[ufc_pkg::SC_RI]   = receive_done_flag[i];
         end
         if (is_at(addr_i, ufc_pkg::OFF_OWN_ADDRESS[i])) begin
            next_rdata = own_address[i];
         end
         if (is_at(addr_i, ufc_pkg::OFF_ADDRESS_MASK[i])) begin
            next_rdata = own_address_mask[i];
         end
         if (is_at(addr_i, ufc_pkg::OFF_BAUD_CONTROL[i])) begin
            next_rdata[ufc_pkg::BC_TXBG] = tx_baudgen_select[i];
            next_rdata[ufc_pkg::BC_RXBG] = rx_baudgen_select[i];
            if (i == 1) begin
               next_rdata[ufc_pkg::BC_FCE1] = frame_check_enable[1];
            end
         end
      end
      if (is_at(addr_i, ufc_pkg::OFF_POWER_CONTROL)) begin
         next_rdata[ufc_pkg::PC_FCE0] = frame_check_enable[0];
      end
      if (is_at(addr_i, ufc_pkg::OFF_TIMER_TWO_CTRL)) begin
         next_rdata[ufc_pkg::T2_TXT2] = tx_timer_two_select;
         next_rdata[ufc_pkg::T2_RXT2] = rx_timer_two_select;
      end
      if (is_at(addr_i, ufc_pkg::OFF_IRQ_STATUS)) begin
         next_rdata[ufc_pkg::IRQ_W-1:0] = irq_status;
      end
      if (is_at(addr_i, ufc_pkg::OFF_IRQ_MASK)) begin
         next_rdata[ufc_pkg::IRQ_W-1:0] = irq_mask;
      end
   end

   // Read data stands one cycle
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rd_i ? next_rdata : 8'h00;
      end
   end

endmodule // ufc_uart_frame_check

// >>> sim/ufc_remote_node.sv
module ufc_remote_node (
   // Clock
   input  wire logic            clk_i,
   // Receive strobes toward the block
   output ufc_pkg::ufc_rx_evt_s evt_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet lines at start
   initial evt_o = '0;

   // Last data bit
   task automatic last(input logic [7:0] d, input logic nb);
      evt_o <= '{1'b1, 1'b0, d, nb, 1'b0};
      @(posedge clk_i);
      evt_o <= '{1'b0, 1'b0, ~d, ~nb, 1'b1}; // Inverse while idle
      @(posedge clk_i);
   endtask

   // Stop bit, data held for mode 1 filtering
   task automatic stop(input logic [7:0] d, input logic nb, input logic ok);
      evt_o <= '{1'b0, 1'b1, d, nb, ok};
      @(posedge clk_i);
      evt_o <= '{1'b0, 1'b0, ~d, ~nb, ~ok};
      @(posedge clk_i);
   endtask
endmodule // ufc_remote_node

// >>> sim/ufc_monitor.sv
module ufc_monitor (
   // Clock, reset and register port
   input wire logic                       clk_sys_i,
   input wire logic                       nrst_i,
   input wire logic [7:0]                 addr_i,
   input wire logic [7:0]                 wdata_i,
   input wire logic                       wr_i,
   input wire logic                       rd_i,
   input wire logic [7:0]                 rdata_o,
   // Serial side
   input wire ufc_pkg::ufc_rx_evt_s [1:0] rx_evt_i,
   input wire logic [1:0]                 tx_done_i,
   input wire logic                       timer1_tick_i,
   input wire logic                       timer2_tick_i,
   input wire logic [1:0]                 baud_gen_tick_i,
   input wire ufc_pkg::ufc_ctrl_s [1:0]   ctrl_o,
   input wire logic [1:0]                 tx_baud_tick_o,
   input wire logic [1:0]                 rx_baud_tick_o,
   input wire logic                       irq_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   logic [7:0] bc_q [2];
   logic [7:0] t2_q;
   logic [1:0] exp_tx;
   logic [1:0] exp_rx;

   // Shadow of the clock selects
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         bc_q <= '{default: 8'h00};
         t2_q <= 8'h00;
      end else if (wr_i) begin
         for (int p = 0; p < 2; p++) begin
            if (addr_i == ufc_pkg::OFF_BAUD_CONTROL[p]) bc_q[p] <= wdata_i;
         end
         if (addr_i == ufc_pkg::OFF_TIMER_TWO_CTRL) t2_q <= wdata_i;
      end
   end

   // Expected tick source
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         exp_tx[p] = bc_q[p][ufc_pkg::BC_TXBG] ? baud_gen_tick_i[p] :
                     t2_q[ufc_pkg::T2_TXT2] ? timer2_tick_i : timer1_tick_i;
         exp_rx[p] = bc_q[p][ufc_pkg::BC_RXBG] ? baud_gen_tick_i[p] :
                     t2_q[ufc_pkg::T2_RXT2] ? timer2_tick_i : timer1_tick_i;
      end
   end

   for (genvar p = 0; p < 2; p++) begin : g_port
      // Mode 0 strobe
      sequence s_shift_last;
         rx_evt_i[p].last_data ##1 ctrl_o[p].mode == ufc_pkg::UFC_MODE_SHIFT;
      endsequence
      property p_tx_sel;
         tx_baud_tick_o[p] == (ctrl_o[p].mode[0] && $past(exp_tx[p]));
      endproperty
      property p_rx_sel;
         rx_baud_tick_o[p] == (ctrl_o[p].mode[0] && $past(exp_rx[p]));
      endproperty
      property p_ri_mode0;
         s_shift_last |-> ##1 ctrl_o[p].ri;
      endproperty
      property p_ri_cause;
         $rose(ctrl_o[p].ri) && !$past(wr_i, 2) |-> $past(rx_evt_i[p].last_data || rx_evt_i[p].stop, 2);
      endproperty
      property p_ri_stop1;
         $rose(ctrl_o[p].ri) && !$past(wr_i, 2) && ctrl_o[p].mode == ufc_pkg::UFC_MODE_UART8
            |-> $past(rx_evt_i[p].stop, 2);
      endproperty
      property p_ti_set;
         tx_done_i[p] |-> ##2 ctrl_o[p].ti;
      endproperty
      a_tx_sel: assert property (p_tx_sel) else $error("tx tick source wrong");
      a_rx_sel: assert property (p_rx_sel) else $error("rx tick source wrong");
      a_ri_mode0: assert property (p_ri_mode0) else $error("mode 0 receive-done missing");
      a_ri_cause: assert property (p_ri_cause) else $error("receive-done without strobe");
      a_ri_stop1: assert property (p_ri_stop1) else $error("mode 1 receive-done not at stop");
      a_ti_set: assert property (p_ti_set) else $error("transmit-done flag missing");
   end

   property p_irq_fall;
      $fell(irq_o) |-> $past(wr_i, 2);
   endproperty
   property p_rdata_idle;
      !$past(rd_i) |-> rdata_o == 8'h00;
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without write");
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
endmodule // ufc_monitor

bind ufc_uart_frame_check ufc_monitor u_mon (.*);

// >>> sim/testbench.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got=%h exp=%h", $time, g, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                            clk_sys_i, nrst_i, wr_i, rd_i, timer1_tick_i, timer2_tick_i, irq_o;
   logic [7:0]                      addr_i, wdata_i, rdata_o;
   logic [1:0]                      tx_done_i, baud_gen_tick_i, tx_baud_tick_o, rx_baud_tick_o;
   ufc_pkg::ufc_rx_evt_s            evt0, evt1;
   wire ufc_pkg::ufc_rx_evt_s [1:0] rx_evt_i = {evt1, evt0};
   ufc_pkg::ufc_ctrl_s [1:0]        ctrl_o;
   int                              err_total = 0;
   int                              checks = 0;
   // {serial control, address, ninth, stop ok, expect receive-done}
   localparam logic [23:0] TV [12] = '{24'hf054e0, 24'hf057e0, 24'hf050c0, 24'hf0fee0, 24'hf0ffe0,
      24'hf07ec0, 24'hf05640, 24'hd07ee0, 24'h7054e0, 24'h705480, 24'h7050c0, 24'h305060};

   ufc_uart_frame_check DUT (.*);
   ufc_remote_node node0 (.clk_i(clk_sys_i), .evt_o(evt0));
   ufc_remote_node node1 (.clk_i(clk_sys_i), .evt_o(evt1));

   function automatic logic [7:0] sc(input int p);
      return ufc_pkg::OFF_SERIAL_CONTROL[p];
   endfunction

   // Gap edge so no strobe is set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(posedge clk_sys_i);
      v = rdata_o;
   endtask

   // One frame; mid samples receive-done before the stop bit
   task automatic frm(input int p, input logic [7:0] d, input logic nb, input logic ok, output logic mid);
      if (p == 1) node1.last(d, nb);
      else node0.last(d, nb);
      repeat (2) @(posedge clk_sys_i);
      mid = ctrl_o[p].ri;
      if (p == 1) node1.stop(d, nb, ok);
      else node0.stop(d, nb, ok);
      repeat (2) @(posedge clk_sys_i);
   endtask

   task automatic t_regs();
      logic [7:0] v;
      logic       m;
      wr(sc(0), 8'hf0);
      frm(0, 8'h9a, 1'b1, 1'b1, m);
      rd(sc(0), v);
      `CHK(v[0], 1'b1)
      for (int i = 0; i < 5; i++) begin
         rd(i == 4 ? 8'h86 : 8'ha9 + 8'(i % 2) + (i > 1 ? 8'h10 : 8'h00), v);
         `CHK(v, 8'h00)
      end
      wr(8'ha9, 8'h56);
      rd(8'ha9, v);
      `CHK(v, 8'h56)
   endtask

   // Mode 3 set while bit 7 still maps to the mode
   task automatic t_fe(input int p, input logic [7:0] fa);
      logic [7:0] v;
      logic       m;
      wr(fa, 8'h00);
      wr(sc(p), 8'hd0);
      wr(fa, 8'h40);
      frm(p, 8'h3c, 1'b1, 1'b0, m);
      `CHK(m, 1'b0)
      rd(sc(p), v);
      `CHK(v[7], 1'b1)
      `CHK(v[0], 1'b1)
      `CHK(v[2], 1'b1)
      wr(sc(p), 8'hd0);
      frm(p, 8'h3c, 1'b1, 1'b1, m);
      rd(sc(p), v);
      `CHK(v[7], 1'b1)
      wr(sc(p), 8'h50);
      rd(sc(p), v);
      `CHK(v[7], 1'b0)
      wr(fa, 8'h00);
      rd(sc(p), v);
      `CHK(v[7], 1'b1)
      wr(sc(p), 8'h10);
      wr(fa, 8'h40);
      frm(p, 8'h3c, 1'b0, 1'b0, m);
      rd(sc(p), v);
      `CHK(v[7], 1'b0)
      `CHK(v[0], 1'b1)
      wr(fa, 8'h00);
   endtask

   task automatic t_addr(input int p);
      logic [7:0] v;
      logic       m;
      wr(ufc_pkg::OFF_OWN_ADDRESS[p], 8'h56);
      wr(ufc_pkg::OFF_ADDRESS_MASK[p], 8'hfc);
      foreach (TV[i]) begin
         wr(sc(p), TV[i][23:16]);
         frm(p, TV[i][15:8], TV[i][7], TV[i][6], m);
         rd(sc(p), v);
         `CHK(v[0], TV[i][5])
      end
   endtask

   // Masked status must not reach the pin
   task automatic t_irq();
      logic [7:0] v;
      logic       m;
      wr(ufc_pkg::OFF_IRQ_STATUS, 8'h3f);
      wr(ufc_pkg::OFF_IRQ_MASK, 8'h01);
      wr(sc(0), 8'h50);
      frm(0, 8'h11, 1'b0, 1'b1, m);
      `CHK(irq_o, 1'b1)
      wr(ufc_pkg::OFF_IRQ_MASK, 8'h10);
      @(posedge clk_sys_i);
      `CHK(irq_o, 1'b0)
      tx_done_i <= 2'b10;
      @(posedge clk_sys_i);
      tx_done_i <= 2'b00;
      rd(ufc_pkg::OFF_IRQ_STATUS, v);
      `CHK(v, 8'h11)
      `CHK(irq_o, 1'b1)
      wr(ufc_pkg::OFF_IRQ_STATUS, 8'h10);
      @(posedge clk_sys_i);
      `CHK(irq_o, 1'b0)
   endtask

   // Transmit and receive selects differ in combinations 2 and 4 to 7
   task automatic t_baud();
      for (int p = 0; p < 2; p++) begin
         wr(sc(p), 8'h50);
         for (int i = 0; i < 8; i++) begin
            wr(ufc_pkg::OFF_TIMER_TWO_CTRL, {2'b00, i[2], i[1], 4'h0});
            wr(ufc_pkg::OFF_BAUD_CONTROL[p], {4'h0, i[0], i[2] ^ i[0], 2'b00});
            for (int s = 0; s < 3; s++) begin
               timer1_tick_i <= (s == 0);
               timer2_tick_i <= (s == 1);
               baud_gen_tick_i[p] <= (s == 2);
               @(posedge clk_sys_i);
               {timer1_tick_i, timer2_tick_i, baud_gen_tick_i} <= '0;
               @(posedge clk_sys_i);
               `CHK(tx_baud_tick_o[p], i[0] ? s == 2 : i[1] ? s == 1 : s == 0)
               `CHK(rx_baud_tick_o[p], (i[2] ^ i[0]) ? s == 2 : i[2] ? s == 1 : s == 0)
            end
         end
      end
   endtask

   task automatic close_out();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Clock
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   // Hang guard, well past the test length
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_total++;
      close_out();
   end

   // Main sequence
   initial begin
      {nrst_i, wr_i, rd_i, timer1_tick_i, timer2_tick_i, baud_gen_tick_i, tx_done_i, addr_i, wdata_i} = '0;
      repeat (12) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      t_regs();
      t_fe(0, ufc_pkg::OFF_POWER_CONTROL);
      t_fe(1, ufc_pkg::OFF_BAUD_CONTROL[1]);
      t_addr(1);
      t_irq();
      t_baud();
      close_out();
   end
endmodule // testbench
